// *** ilth_defs.vh ***
`ifndef ILTH_DEFS_VH
`define ILTH_DEFS_VH

// ------------------------------------------------------------
// Control latch bit addresses (processor side)
// ------------------------------------------------------------
`define ILTH_Q_NRFD 3'h1
`define ILTH_Q_DAV 3'h2
`define ILTH_Q_MLA 3'h4
`define ILTH_Q_DAVREQ 3'h5
`define ILTH_Q_NDACREL 3'h6
`define ILTH_Q_DRVEN 3'h7

// ------------------------------------------------------------
// Control latch reset values
// ------------------------------------------------------------
`define ILTH_RST_NRFD 1'b0
`define ILTH_RST_DAV 1'b0
`define ILTH_RST_MLA 1'b0
`define ILTH_RST_DAVREQ 1'b0
`define ILTH_RST_NDACREL 1'b0
`define ILTH_RST_DRVEN 1'b0

// ------------------------------------------------------------
// Status word bit positions
// ------------------------------------------------------------
`define ILTH_ST_RTS 0
`define ILTH_ST_ACC 1
`define ILTH_ST_LISTEN 2
`define ILTH_ST_VALID 3
`define ILTH_ST_DONE 4
`define ILTH_ST_REMOTE 5
`define ILTH_ST_ATN 6
`define ILTH_ST_TALK 7

// ------------------------------------------------------------
// Synchroniser width and number of driven data bits
// ------------------------------------------------------------
`define ILTH_SYNC_W 12
`define ILTH_OUT_BITS 7

`endif

// *** ilth_sync.v ***
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Two-stage synchroniser for asynchronous bus lines
// ------------------------------------------------------------
module ilth_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Asynchronous input and synchronised output
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);

   // First stage; only the second stage reads it
   reg [WIDTH-1:0] meta_q;

   // Both stages reset to released (high) bus levels
   always @(posedge core_clk) begin
      if (rst) begin
         meta_q <= RST_VAL;
         syncOut <= RST_VAL;
      end else begin
         meta_q <= asyncIn;
         syncOut <= meta_q;
      end
   end

endmodule

`default_nettype wire

// *** ilth_handshake.v ***
// Notes on behaviour
// - Pair received bytes; store combined program word.
// - After data read, drive NRFD low.
// - Releasing NDAC drive clears data-valid interrupt.
// - DAV high while NRFD held raises completion.
// - Re-assert NDAC, release NRFD clears completion.
// - Talk only when addressed and ATN false.
// - Talk request, no ATN, NRFD high: interrupt.
// - Processor loads byte, enables DIO1-DIO7 drivers.
// - Drive DAV low, clear talk request.
// - NDAC high while driving DAV: accepted interrupt.
// - Set talk request, release DAV, clears interrupt.
// - Program bytes only when listener and remote.
// - Status bit 3 valid, bit 4 done.
// - NDAC driven only under ATN or listen.
`include "ilth_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ilth_handshake (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Bus pins, all negative logic (low = true)
   input wire atnN,
   input wire davNIn,
   output wire davNOut,
   output reg davNOeN_q,
   input wire nrfdNIn,
   output wire nrfdNOut,
   output reg nrfdNOeN_q,
   input wire ndacNIn,
   output wire ndacNOut,
   output reg ndacNOeN_q,
   input wire [7:0] dioNIn,
   output reg [7:0] dioNOut_q,
   output reg [7:0] dioNOeN_q,
   // Addressing from the command decoder
   input wire talkAddr,
   input wire remoteEn,
   // Processor control latch writes
   input wire ctlWr,
   input wire [2:0] ctlAddr,
   input wire ctlVal,
   // Processor output data latch
   input wire outWr,
   input wire [7:0] outData,
   // Processor read of received byte
   input wire dataRd,
   output reg [7:0] rxByte_q,
   // Status and interrupt
   output reg [7:0] statusWord_q,
   output reg procIrq_q,
   // Program word assembly
   output reg [15:0] progWord_q,
   output reg progStb_q,
   output reg progPending_q,
   output reg [7:0] annunN_q
);

   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------

   // Synchronised copies, still negative logic
   wire [11:0] syncBus;
   wire atnS;
   wire davS;
   wire nrfdS;
   wire ndacS;
   wire [7:0] dioS;

   // Every bus line comes from another instrument; no common clock
   ilth_sync #(
      .WIDTH(`ILTH_SYNC_W),
      .RST_VAL({`ILTH_SYNC_W{1'b1}})
   ) uSync (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn({atnN, davNIn, nrfdNIn, ndacNIn, dioNIn}),
      .syncOut(syncBus)
   );

   assign atnS = syncBus[11];
   assign davS = syncBus[10];
   assign nrfdS = syncBus[9];
   assign ndacS = syncBus[8];
   assign dioS = syncBus[7:0];

   // Open-drain pins only ever pull low
   assign davNOut = 1'b0;
   assign nrfdNOut = 1'b0;
   assign ndacNOut = 1'b0;

   // ------------------------------------------------------------
   // Control latch (addressable bits)
   // ------------------------------------------------------------

   reg nrfd_q;      // Hold NRFD true
   reg dav_q;       // Hold DAV true
   reg mla_q;       // Addressed as listener
   reg davReq_q;    // Talk request
   reg ndacRel_q;   // High releases NDAC (false)
   reg drvEn_q;     // Data driver enable

   // Single-bit writes, like an addressable latch
   always @(posedge core_clk) begin
      if (rst) begin
         nrfd_q <= `ILTH_RST_NRFD;
         dav_q <= `ILTH_RST_DAV;
         mla_q <= `ILTH_RST_MLA;
         davReq_q <= `ILTH_RST_DAVREQ;
         ndacRel_q <= `ILTH_RST_NDACREL;
         drvEn_q <= `ILTH_RST_DRVEN;
      end else if (ctlWr) begin
         // Unused addresses are ignored
         if (ctlAddr == `ILTH_Q_NRFD) begin
            nrfd_q <= ctlVal;
         end else if (ctlAddr == `ILTH_Q_DAV) begin
            dav_q <= ctlVal;
         end else if (ctlAddr == `ILTH_Q_MLA) begin
            mla_q <= ctlVal;
         end else if (ctlAddr == `ILTH_Q_DAVREQ) begin
            davReq_q <= ctlVal;
         end else if (ctlAddr == `ILTH_Q_NDACREL) begin
            ndacRel_q <= ctlVal;
         end else if (ctlAddr == `ILTH_Q_DRVEN) begin
            drvEn_q <= ctlVal;
         end
      end
   end

   // ------------------------------------------------------------
   // Qualified bus conditions (positive logic)
   // ------------------------------------------------------------

   wire atnTrue;
   wire davTrue;
   wire nrfdTrue;
   wire ndacTrue;
   wire listenQual;
   wire ndacDrive;
   wire davDrive;
   wire talkOk;

   assign atnTrue = ~atnS;
   assign davTrue = ~davS;
   assign nrfdTrue = ~nrfdS;
   assign ndacTrue = ~ndacS;

   // Commands under ATN or data while listening
   assign listenQual = atnTrue | mla_q;
   // NDAC pulled only when the listener path is qualified
   assign ndacDrive = ~ndacRel_q & listenQual;
   // Talking is blocked in command mode
   assign talkOk = talkAddr & ~atnTrue;
   assign davDrive = dav_q & talkOk;

   // ------------------------------------------------------------
   // Interrupt sources
   // ------------------------------------------------------------

   wire irqValid;
   wire irqDone;
   wire irqRts;
   wire irqAcc;

   // Data valid; dropped as soon as NDAC is released
   assign irqValid = davTrue & ~ndacRel_q & listenQual;
   // Byte complete: DAV gone false while NRFD held
   assign irqDone = nrfd_q & ~davTrue;
   // Ready to send; clearing the request removes it
   assign irqRts = davReq_q & ~atnTrue & ~nrfdTrue;
   // Byte accepted while we hold DAV; relies on far-end order
   assign irqAcc = davDrive & ~ndacTrue;

   // Level interrupt, cleared by the handshake bits themselves
   always @(posedge core_clk) begin
      if (rst) begin
         procIrq_q <= 1'b0;
      end else begin
         procIrq_q <= irqValid | irqDone | irqRts | irqAcc;
      end
   end

   // ------------------------------------------------------------
   // Status word
   // ------------------------------------------------------------

   // Rebuilt every cycle; reads never disturb it
   always @(posedge core_clk) begin
      if (rst) begin
         statusWord_q <= 8'h00;
      end else begin
         statusWord_q[`ILTH_ST_RTS] <= irqRts;
         statusWord_q[`ILTH_ST_ACC] <= irqAcc;
         statusWord_q[`ILTH_ST_LISTEN] <= mla_q;
         statusWord_q[`ILTH_ST_VALID] <= irqValid;
         statusWord_q[`ILTH_ST_DONE] <= irqDone;
         statusWord_q[`ILTH_ST_REMOTE] <= remoteEn;
         statusWord_q[`ILTH_ST_ATN] <= atnTrue;
         statusWord_q[`ILTH_ST_TALK] <= talkAddr;
      end
   end

   // ------------------------------------------------------------
   // Handshake line drivers
   // ------------------------------------------------------------

   // Enables are active low: low means pulling the line low
   always @(posedge core_clk) begin
      if (rst) begin
         davNOeN_q <= 1'b1;
         nrfdNOeN_q <= 1'b1;
         ndacNOeN_q <= 1'b1;
      end else begin
         davNOeN_q <= ~davDrive;
         nrfdNOeN_q <= ~nrfd_q;
         ndacNOeN_q <= ~ndacDrive;
      end
   end

   // ------------------------------------------------------------
   // Output data latch and DIO drivers
   // ------------------------------------------------------------

   reg [7:0] outLatch_q;   // Byte staged by the processor

   // Load is independent of the enable so data can settle first
   always @(posedge core_clk) begin
      if (rst) begin
         outLatch_q <= 8'h00;
      end else if (outWr) begin
         outLatch_q <= outData;
      end
   end

   // Only DIO1..DIO7 are driven; DIO8 always released
   always @(posedge core_clk) begin
      if (rst) begin
         dioNOut_q <= 8'hff;
         dioNOeN_q <= 8'hff;
      end else begin
         dioNOut_q <= {1'b1, ~outLatch_q[`ILTH_OUT_BITS-1:0]};
         if (drvEn_q & talkOk) begin
            dioNOeN_q <= 8'h80;
         end else begin
            dioNOeN_q <= 8'hff;
         end
      end
   end

   // ------------------------------------------------------------
   // Received byte capture
   // ------------------------------------------------------------

   wire progAccept;
   // Program data only when listening, remote, and not a command
   assign progAccept = dataRd & mla_q & remoteEn & ~atnTrue;

   // Read strobe samples the data lines (true = low)
   always @(posedge core_clk) begin
      if (rst) begin
         rxByte_q <= 8'h00;
      end else if (dataRd) begin
         rxByte_q <= ~dioS;
      end
   end

   // ------------------------------------------------------------
   // Program word pairing
   // ------------------------------------------------------------

   reg [7:0] firstByte_q;   // First byte of a step, held pending

   // Two bytes per step; an odd byte stays pending
   always @(posedge core_clk) begin
      if (rst) begin
         firstByte_q <= 8'h00;
         progPending_q <= 1'b0;
         progWord_q <= 16'h0000;
         progStb_q <= 1'b0;
         annunN_q <= 8'hff;
      end else begin
         progStb_q <= 1'b0;
         if (progAccept) begin
            if (!progPending_q) begin
               firstByte_q <= ~dioS;
               progPending_q <= 1'b1;
            end else begin
               progWord_q <= {firstByte_q, ~dioS};
               progStb_q <= 1'b1;
               progPending_q <= 1'b0;
               // Low lights the lamp chosen by the first byte
               annunN_q <= ~(8'h01 << firstByte_q[2:0]);
            end
         end else if (!mla_q) begin
            // Unlisten drops a half-received step
            progPending_q <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// *** ilth_handshake_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// --------------------------
// Handshake port checker
// --------------------------
module ilth_handshake_chk (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Bus side ports
   input wire atnN,
   input wire talkAddr,
   input wire davNOeN_q,
   input wire nrfdNOeN_q,
   input wire ndacNOeN_q,
   input wire [7:0] dioNOut_q,
   input wire [7:0] dioNOeN_q,
   // Processor side ports
   input wire ctlWr,
   input wire [2:0] ctlAddr,
   input wire ctlVal,
   input wire dataRd,
   input wire [7:0] statusWord_q,
   input wire procIrq_q,
   input wire [15:0] progWord_q,
   input wire progStb_q,
   input wire progPending_q,
   input wire [7:0] annunN_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Latch writes; a rewrite next cycle would mask the result
   wire wNrfd = ctlWr && ctlAddr == 3'h1;
   wire wNdac = ctlWr && ctlAddr == 3'h6;
   a_nrfd_follow: assert property (
      wNrfd ##1 !wNrfd |=> nrfdNOeN_q == !$past(ctlVal, 2)) else $error("nrfd drive");
   a_ndac_release: assert property (
      wNdac && ctlVal ##1 !wNdac |=> ndacNOeN_q) else $error("ndac kept");
   // Synchroniser needs a few cycles of steady ATN first
   a_ndac_cmd: assert property (
      (!atnN)[*3] ##1 (!atnN && wNdac && !ctlVal) ##1 (!atnN && !wNdac)
      |=> !ndacNOeN_q) else $error("ndac not driven");
   a_talk_gate: assert property (
      (!talkAddr)[*3] |-> davNOeN_q && dioNOeN_q == 8'hff) else $error("talk unaddressed");
   a_atn_gate: assert property (
      (!atnN)[*4] |-> davNOeN_q && dioNOeN_q == 8'hff && statusWord_q[1:0] == 2'h0)
      else $error("talk under atn");
   a_dio_shape: assert property (
      (dioNOeN_q == 8'h80 || dioNOeN_q == 8'hff) && dioNOut_q[7]) else $error("dio drive");
   a_irq_sum: assert property (
      procIrq_q == (|{statusWord_q[4:3], statusWord_q[1:0]})) else $error("irq sum");
   a_pair_store: assert property (
      progStb_q |-> $past(dataRd) && $past(progPending_q) && !progPending_q)
      else $error("pair store");
   a_lamp_sel: assert property (
      progStb_q |-> annunN_q == ~(8'h01 << progWord_q[10:8])) else $error("lamp select");
   a_reset_idle: assert property (
      $past(rst) |-> davNOeN_q && nrfdNOeN_q && ndacNOeN_q && !procIrq_q)
      else $error("reset state");
   // Main scenarios reached
   c_pair: cover property (progStb_q);
   c_done: cover property (statusWord_q[4]);
   c_acc: cover property (statusWord_q[1]);
endmodule
bind ilth_handshake ilth_handshake_chk chk_u (.core_clk, .rst, .atnN, .talkAddr, .davNOeN_q,
   .nrfdNOeN_q, .ndacNOeN_q, .dioNOut_q, .dioNOeN_q, .ctlWr, .ctlAddr, .ctlVal, .dataRd,
   .statusWord_q, .procIrq_q, .progWord_q, .progStb_q, .progPending_q, .annunN_q);
`default_nettype wire

// *** ilth_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// --------------------------
// Far-side bus parties
// --------------------------
module ilth_bus_model (
   // Clock
   input wire core_clk,
   // Device drives, low pulls the line
   input wire davNOeN,
   input wire nrfdNOeN,
   input wire ndacNOeN,
   input wire [7:0] dioNOeN,
   input wire [7:0] dioNOut,
   // Controller drive and acceptor pacing
   input wire ctlDavN,
   input wire [7:0] ctlDioN,
   input wire talkMode,
   input wire [3:0] slow,
   // Resolved lines, pulled up when free
   output wire davLine,
   output wire nrfdLine,
   output wire ndacLine,
   output wire [7:0] dioLine
);
   logic accNrfd = 1'h1;
   logic accNdac = 1'h1;
   logic davSeen = 1'h1;
   logic [3:0] waitCnt = 4'h0;
   // Wired AND of every party on each line
   assign davLine = ctlDavN & davNOeN;
   assign nrfdLine = accNrfd & nrfdNOeN;
   assign ndacLine = accNdac & ndacNOeN;
   assign dioLine = ctlDioN & (dioNOut | dioNOeN);
   // Acceptor; slow sets the lag after each DAV edge
   always @(posedge core_clk) begin
      davSeen <= davLine;
      waitCnt <= (davLine != davSeen || !talkMode) ? 4'h0 : waitCnt + {3'h0, waitCnt != 4'hf};
      if (!talkMode) begin
         {accNrfd, accNdac} <= 2'h3;
      end else if (!davLine) begin
         accNrfd <= 1'h0;
         // Stale count from the last phase must not answer at the DAV edge itself
         if (waitCnt >= slow && davLine == davSeen) accNdac <= 1'h1;
      end else begin
         accNdac <= 1'h0;
         if (waitCnt >= slow && davLine == davSeen) accNrfd <= 1'h1;
      end
   end
endmodule
`default_nettype wire

// *** ilth_handshake_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// --------------------------
// Processor and controller bench
// --------------------------
module ilth_handshake_test;
   // Stimulus, changed at falling edges
   logic core_clk = 1'h0, rst = 1'h1, atnN = 1'h1, talkAddr = 1'h0, remoteEn = 1'h0;
   logic ctlWr = 1'h0, ctlVal = 1'h0, outWr = 1'h0, dataRd = 1'h0, ctlDavN = 1'h1;
   logic talkMode = 1'h0;
   logic [2:0] ctlAddr = 3'h0;
   logic [3:0] slow = 4'h0;
   logic [7:0] outData = 8'h00, ctlDioN = 8'hff, b1, b2;
   int mismatches = 0, n_compared = 0, k;
   // Design outputs and resolved lines
   wire davLine, nrfdLine, ndacLine, davNOeN_q, nrfdNOeN_q, ndacNOeN_q;
   wire procIrq_q, progStb_q, progPending_q;
   wire [7:0] dioLine, dioNOut_q, dioNOeN_q, rxByte_q, statusWord_q, annunN_q;
   wire [15:0] progWord_q;
   ilth_handshake dut_u (.core_clk, .rst, .atnN, .davNIn(davLine), .davNOut(), .davNOeN_q,
      .nrfdNIn(nrfdLine), .nrfdNOut(), .nrfdNOeN_q, .ndacNIn(ndacLine), .ndacNOut(),
      .ndacNOeN_q, .dioNIn(dioLine), .dioNOut_q, .dioNOeN_q, .talkAddr, .remoteEn, .ctlWr,
      .ctlAddr, .ctlVal, .outWr, .outData, .dataRd, .rxByte_q, .statusWord_q, .procIrq_q,
      .progWord_q, .progStb_q, .progPending_q, .annunN_q);
   ilth_bus_model bus_u (.core_clk, .davNOeN(davNOeN_q), .nrfdNOeN(nrfdNOeN_q),
      .ndacNOeN(ndacNOeN_q), .dioNOeN(dioNOeN_q), .dioNOut(dioNOut_q), .ctlDavN, .ctlDioN,
      .talkMode, .slow, .davLine, .nrfdLine, .ndacLine, .dioLine);
   // 100 MHz clock
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   // Lamp expected for a program step, active low
   function automatic logic [7:0] lampOf(input logic [7:0] first);
      lampOf = ~(8'h01 << first[2:0]);
   endfunction
   // Compare and count
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One latch write; a free cycle follows so strobes never merge
   task automatic wr(input logic [2:0] a, input logic v);
      @(negedge core_clk);
      {ctlWr, ctlAddr, ctlVal} = {1'h1, a, v};
      @(negedge core_clk);
      ctlWr = 1'h0;
   endtask
   // Bounded wait on one status bit
   task automatic waitSt(input int b, input logic v);
      for (int i = 0; i < 60 && statusWord_q[b] !== v; i++) @(negedge core_clk);
      chk("status bit", {15'h0, v}, {15'h0, statusWord_q[b]});
   endtask
   // Controller sends one program byte; bench plays the processor
   task automatic rx(input logic [7:0] b, input logic second);
      @(negedge core_clk);
      {ctlDioN, ctlDavN} = {~b, 1'h0};
      waitSt(3, 1'h1);
      dataRd = 1'h1;
      @(negedge core_clk);
      dataRd = 1'h0;
      // Strobe stands one cycle only, so look at it now
      chk("strobe", {15'h0, second}, {15'h0, progStb_q});
      @(negedge core_clk);
      chk("rx", {b, 7'h0, !second && remoteEn}, {rxByte_q, 7'h0, progPending_q});
      if (second) chk("word", {b1, b}, progWord_q);
      if (second) chk("lamp", {lampOf(b1), 8'h00}, {annunN_q, 7'h0, progStb_q});
      wr(3'h1, 1'h1);
      wr(3'h6, 1'h1);
      chk("nrfd pull", 16'h0, {15'h0, nrfdNOeN_q});
      waitSt(3, 1'h0);
      for (int i = 0; i < 60 && ndacLine !== 1'h1; i++) @(negedge core_clk);
      ctlDavN = 1'h1;
      waitSt(4, 1'h1);
      wr(3'h6, 1'h0);
      wr(3'h1, 1'h0);
      chk("ndac pull", 16'h0, {15'h0, ndacNOeN_q});
      waitSt(4, 1'h0);
   endtask
   // Device talks one measurement byte
   task automatic tx(input logic [7:0] b);
      waitSt(0, 1'h1);
      @(negedge core_clk);
      {outWr, outData} = {1'h1, b};
      @(negedge core_clk);
      outWr = 1'h0;
      wr(3'h7, 1'h1);
      @(negedge core_clk);
      chk("dio line", {8'h0, 1'h1, ~b[6:0]}, {8'h0, dioLine});
      wr(3'h2, 1'h1);
      wr(3'h5, 1'h0);
      chk("dav pull", 16'h0, {15'h0, davNOeN_q});
      waitSt(1, 1'h1);
      wr(3'h5, 1'h1);
      wr(3'h2, 1'h0);
      @(negedge core_clk);
      chk("dav free", 16'h1, {15'h0, davNOeN_q});
      waitSt(1, 1'h0);
   endtask
   // Single exit point
   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Hang guard, far beyond the expected run
   initial begin
      #300000;
      mismatches++;
      print_verdict();
   end
   // Main sequence
   initial begin
      void'($urandom(32'h8d0c));
      repeat (3) @(negedge core_clk);
      rst = 1'h0;
      @(negedge core_clk);
      chk("idle", 16'he000, {davNOeN_q, nrfdNOeN_q, ndacNOeN_q, procIrq_q, 4'h0, statusWord_q});
      // Command mode blocks talking, pulls NDAC
      {atnN, talkAddr} = 2'h1;
      repeat (3) @(negedge core_clk);
      wr(3'h6, 1'h0);
      wr(3'h2, 1'h1);
      wr(3'h7, 1'h1);
      wr(3'h5, 1'h1);
      repeat (4) @(negedge core_clk);
      chk("atn", 16'h08ff, {4'h0, davNOeN_q, ndacNOeN_q, statusWord_q[0], 1'h0, dioNOeN_q});
      wr(3'h2, 1'h0);
      wr(3'h7, 1'h0);
      wr(3'h5, 1'h0);
      {atnN, talkAddr} = 2'h2;
      repeat (4) @(negedge core_clk);
      chk("ndac free", 16'h1, {15'h0, ndacNOeN_q});
      // Listener: program byte pairs, corner values first
      remoteEn = 1'h1;
      wr(3'h4, 1'h1);
      for (k = 0; k < 4; k++) begin
         b1 = k == 0 ? 8'h07 : 8'($urandom);
         b2 = k == 0 ? 8'h00 : 8'($urandom);
         rx(b1, 1'h0);
         rx(b2, 1'h1);
      end
      rx(8'h5a, 1'h0);
      wr(3'h4, 1'h0);
      @(negedge core_clk);
      chk("odd byte", 16'h0, {15'h0, progPending_q});
      // Local mode: bytes are handshaken but never held for pairing
      remoteEn = 1'h0;
      wr(3'h4, 1'h1);
      rx(8'hc3, 1'h0);
      wr(3'h4, 1'h0);
      // Talker, acceptor lag random 0..7, slowest 7 on the second byte
      {talkAddr, talkMode} = 2'h3;
      // Controller lets go of the data lines before we drive them
      ctlDioN = 8'hff;
      wr(3'h5, 1'h1);
      for (k = 0; k < 4; k++) begin
         slow = k == 1 ? 4'h7 : 4'($urandom % 8);
         tx(8'($urandom));
      end
      wr(3'h5, 1'h0);
      wr(3'h7, 1'h0);
      repeat (4) @(negedge core_clk);
      chk("quiet", 16'h00ff, {7'h0, procIrq_q, dioNOeN_q});
      print_verdict();
   end
endmodule
`default_nettype wire
